// >>> lsa_pkg.sv
package lsa_pkg;

    // System clock.
    localparam longint unsigned CLK_HZ = 40_000_000;

    // Register offsets.
    localparam logic [7:0] ADDR_ONOFF = 8'h00;
    localparam logic [7:0] ADDR_LEVEL_ONE = 8'h01;
    localparam logic [7:0] ADDR_LEVEL_TWO = 8'h02;
    localparam logic [7:0] ADDR_LEVEL_THREE = 8'h03;
    localparam logic [7:0] ADDR_LEVEL_FOUR = 8'h04;
    localparam logic [7:0] ADDR_AUDIO_CTRL = 8'h05;
    localparam logic [7:0] ADDR_THRESH = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;

    // Field positions in the audio control register.
    localparam int AUD_SYNC_POS = 0;
    localparam int AUD_AGC_POS = 1;
    localparam int AUD_GAIN_POS = 2;
    localparam int AUD_SPEED_POS = 5;
    localparam int AUD_CORNER_POS = 7;
    // Field positions in the threshold register.
    localparam int THR_CODE_POS = 0;
    localparam int THR_AGC_POS = 4;

    // Reset values.
    localparam logic [3:0] RST_ONOFF = 4'h0;
    localparam logic [7:0] RST_LEVEL = 8'h00;
    localparam logic [7:0] RST_AUDIO_CTRL = 8'h00;
    localparam logic [3:0] RST_THRESH = 4'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // Converter sample rate and full-scale input swing.
    localparam longint unsigned FS_HZ = 32_000;
    localparam longint unsigned FULL_SCALE_MVPP = 1600;

    // High-pass corners and the Q16 one-pole coefficients derived from them.
    localparam longint unsigned HP_CORNER_LOW_HZ = 80;
    localparam longint unsigned HP_CORNER_HIGH_HZ = 510;
    localparam logic [13:0] HP_ALPHA_LOW =
        14'((2 * 314159 * HP_CORNER_LOW_HZ * 65536) / (100000 * FS_HZ));
    localparam logic [13:0] HP_ALPHA_HIGH =
        14'((2 * 314159 * HP_CORNER_HIGH_HZ * 65536) / (100000 * FS_HZ));

    // Refresh rates in hundredths of a hertz and their periods in cycles.
    localparam longint unsigned REFRESH_MID_CHZ = 1500;
    localparam longint unsigned REFRESH_SLOW_CHZ = 760;
    localparam longint unsigned REFRESH_SLOWEST_CHZ = 380;
    localparam longint unsigned REFRESH_MID_CYC = CLK_HZ * 100 / REFRESH_MID_CHZ;
    localparam longint unsigned REFRESH_SLOW_CYC =
        CLK_HZ * 100 / REFRESH_SLOW_CHZ;
    localparam longint unsigned REFRESH_SLOWEST_CYC =
        CLK_HZ * 100 / REFRESH_SLOWEST_CHZ;
    localparam int REFRESH_CNT_W = 24;

    // Gain steps: attenuation as a right shift, and the largest swing each
    // step is meant for, in millivolts peak-to-peak.
    localparam int unsigned GAIN_SHIFT [8] = '{0, 1, 2, 3, 4, 5, 6, 8};
    localparam longint unsigned AGC_LIMIT_MVPP [8] =
        '{10, 20, 40, 85, 170, 400, 800, 1600};
    localparam logic [15:0] ENV_DECAY_SHIFT = 16'h000A;

    // Threshold at the top code, in microvolts.
    localparam longint unsigned THR_TOP_UV = 2700;
    localparam longint unsigned THR_TOP_CODE = 15;

    localparam logic [7:0] LEVEL_MAX = 8'hFF;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsa_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] a;
        logic [15:0] b;
    } lsa_audio_in_t;

    typedef struct packed {
        logic [3:0] on;
        logic [3:0][7:0] code;
    } lsa_sink_out_t;

    // Peak amplitude, in sample units, that a gain step is sized for.
    function automatic logic [15:0] agc_limit(input logic [2:0] code);
        return 16'(AGC_LIMIT_MVPP[code] * 65536 / (2 * FULL_SCALE_MVPP));
    endfunction

    // Threshold amplitude, in sample units, for a threshold code.
    function automatic logic [15:0] thr_limit(input logic [3:0] code);
        return 16'((longint'(code) * THR_TOP_UV * 65536) /
            (THR_TOP_CODE * FULL_SCALE_MVPP * 1000));
    endfunction

endpackage

// >>> lsa_dc_remover.sv
`timescale 1ns/1ps
`default_nettype none

// One-pole DC remover: a slow average of the input is tracked and subtracted.
module lsa_dc_remover
    import lsa_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Mixed samples.
    input wire logic in_valid,
    input wire logic [15:0] in_sample,
    input wire logic corner_high,
    // Filtered samples.
    output logic out_valid,
    output logic signed [16:0] out_sample
);

    typedef struct packed {
        logic [31:0] avg;
        logic signed [16:0] y;
        logic vld;
    } lsa_hp_state_t;

    lsa_hp_state_t st_ff;
    lsa_hp_state_t nxt_st;

    logic signed [33:0] diff;
    logic signed [48:0] prod;
    logic [13:0] alpha;

    always_comb begin
        nxt_st = st_ff;
        alpha = corner_high ? HP_ALPHA_HIGH : HP_ALPHA_LOW; // see (RL7)
        diff = $signed({2'b00, in_sample, 16'h0000}) -
            $signed({2'b00, st_ff.avg});
        prod = diff * $signed({1'b0, alpha});
        nxt_st.vld = in_valid;
        if (in_valid) begin
            nxt_st.avg = st_ff.avg + 32'(prod >>> 16);
            // The output is the input minus its running average.
            nxt_st.y = 17'($signed({1'b0, in_sample}) -
                $signed({1'b0, st_ff.avg[31:16]})); // see (RL7)
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign out_valid = st_ff.vld;
    assign out_sample = st_ff.y;

endmodule

`default_nettype wire

// >>> lsa_led_sink_ctrl.sv
// How it works
// (RL1) Each sink is on/off switched, its current set by an 8-bit code.
// (RL2) Offset 00 holds the four on/off bits; off sinks ignore level.
// (RL3) The DAC code n gives n times 15 mA over 255.
// (RL4) Only sink one follows audio, using the processed signal's peak.
// (RL5) Both audio inputs are averaged into one stream for one filter.
// (RL6) Mix, convert, gain, then peak detect, all on digital samples; the code applies gain to the peak, after detection.
// (RL7) A high-pass removes DC; corner bit picks 80 Hz or 510 Hz.
// (RL8) Audio following runs while its enable bit is one.
// (RL9) With following on, the written sink one level is not used.
// (RL10) Auto gain bit picks automatic gain, else the manual gain field.
// (RL11) Manual gain codes 0 to 7 give 0 down to -46 dB; the code shifts code 7 right by 8, about -48 dB.
// (RL12) Refresh field: fastest, about 15, 7.6 or 3.8 Hz.
// (RL13) Threshold code 0 disables; codes rise to about 2.7 mV.
// (RL14) Auto gain picks the step that fits the input swing.
// (RL15) Host sets a threshold when the audio lines are noisy.
// (RL16) Each refresh tick turns the gained peak into sink one's code.
// (RL17) Peaks under the threshold give sink one zero brightness.
`timescale 1ns/1ps
`default_nettype none

module lsa_led_sink_ctrl
    import lsa_pkg::*;
#(
    parameter int unsigned REFRESH_MID_CYCLES = 32'(REFRESH_MID_CYC),
    parameter int unsigned REFRESH_SLOW_CYCLES =
        32'(REFRESH_SLOW_CYC),
    parameter int unsigned REFRESH_SLOWEST_CYCLES =
        32'(REFRESH_SLOWEST_CYC)
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register access from the serial interface.
    input wire lsa_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Digitised audio from the converter.
    input wire lsa_audio_in_t audio_in,
    // Current sink drive.
    output lsa_sink_out_t sink_out
);

    typedef struct packed {
        logic [3:0] onoff;
        logic [3:0][7:0] level;
        logic sync_en;
        logic agc_en;
        logic [2:0] gain_sel;
        logic [1:0] speed;
        logic corner;
        logic [3:0] thresh;
        logic [7:0] rdata;
        logic [15:0] peak;
        logic [15:0] env;
        logic [2:0] agc_code;
        logic [7:0] audio_level;
        logic [REFRESH_CNT_W-1:0] rcnt;
        logic [3:0] drv_on;
        logic [3:0][7:0] drv_code;
    } lsa_state_t;

    lsa_state_t st_ff;
    lsa_state_t nxt_st;

    logic [16:0] mix_sum;
    logic [15:0] mix;
    logic hp_valid;
    logic signed [16:0] hp_sample;
    logic [16:0] mag_wide;
    logic [15:0] mag;
    logic [15:0] peak_cand;
    logic [15:0] env_decayed;
    logic [2:0] gain_code;
    logic tick;
    logic [REFRESH_CNT_W-1:0] rperiod;

    // Both channels are averaged so that one filter serves the pair.
    assign mix_sum = {1'b0, audio_in.a} + {1'b0, audio_in.b}; // see (RL5)
    assign mix = mix_sum[16:1];

    lsa_dc_remover u_dc_remover (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(audio_in.valid),
        .in_sample(mix),
        .corner_high(st_ff.corner),
        .out_valid(hp_valid),
        .out_sample(hp_sample)
    ); // see (RL6)

    // Amplitude after gain, scaled so the top of gain steps 0 to 6 nears
    // full brightness and the top of step 7 gives 160, then clipped to the DAC range.
    function automatic logic [7:0] level_from_peak(
        input logic [15:0] pk,
        input logic [2:0] code
    );
        logic [15:0] att;
        logic [16:0] scaled;
        att = pk >> GAIN_SHIFT[code]; // see (RL11)
        scaled = {1'b0, att} + {3'b000, att[15:2]};
        return (scaled > 17'(LEVEL_MAX)) ? LEVEL_MAX : scaled[7:0];
    endfunction

    // Smallest attenuation whose range still holds the envelope.
    function automatic logic [2:0] agc_pick(input logic [15:0] envelope);
        logic [2:0] pick;
        pick = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (envelope <= agc_limit(3'(i))) begin
                pick = 3'(i);
            end
        end
        return pick;
    endfunction

    // Period of the selected refresh rate; code 00 has no timer.
    function automatic logic [REFRESH_CNT_W-1:0] refresh_period(
        input logic [1:0] sel
    );
        unique case (sel)
            2'b01: return REFRESH_CNT_W'(REFRESH_MID_CYCLES);
            2'b10: return REFRESH_CNT_W'(REFRESH_SLOW_CYCLES);
            2'b11: return REFRESH_CNT_W'(REFRESH_SLOWEST_CYCLES);
            2'b00: return '0;
        endcase
    endfunction

    // Next count of the refresh timer; it never wraps, as the compare
    // restarts it before the top of its range.
    function automatic logic [REFRESH_CNT_W-1:0] count_up(
        input logic [REFRESH_CNT_W-1:0] cnt
    );
        return cnt + 1'b1;
    endfunction

    // An off sink draws nothing, whatever code it holds.
    function automatic logic [7:0] gate_code(
        input logic on,
        input logic [7:0] code
    );
        return on ? code : 8'h00;
    endfunction

    always_comb begin
        nxt_st = st_ff;

        // Register writes.
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                ADDR_ONOFF: begin
                    nxt_st.onoff = reg_req.wdata[3:0]; // see (RL2)
                end
                ADDR_LEVEL_ONE: begin
                    nxt_st.level[0] = reg_req.wdata;
                end
                ADDR_LEVEL_TWO: begin
                    nxt_st.level[1] = reg_req.wdata;
                end
                ADDR_LEVEL_THREE: begin
                    nxt_st.level[2] = reg_req.wdata;
                end
                ADDR_LEVEL_FOUR: begin
                    nxt_st.level[3] = reg_req.wdata;
                end
                ADDR_AUDIO_CTRL: begin
                    nxt_st.sync_en = reg_req.wdata[AUD_SYNC_POS];
                    nxt_st.agc_en = reg_req.wdata[AUD_AGC_POS];
                    nxt_st.gain_sel = reg_req.wdata[AUD_GAIN_POS +: 3];
                    nxt_st.speed = reg_req.wdata[AUD_SPEED_POS +: 2];
                    nxt_st.corner = reg_req.wdata[AUD_CORNER_POS];
                end
                ADDR_THRESH: begin
                    nxt_st.thresh = reg_req.wdata[THR_CODE_POS +: 4];
                end
                default: begin
                end
            endcase
        end

        // Register reads answer on the next edge; unmapped offsets read 00.
        // A read in the same cycle as a write returns the older value.
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_ONOFF: begin
                    nxt_st.rdata = {4'h0, st_ff.onoff};
                end
                ADDR_LEVEL_ONE: begin
                    nxt_st.rdata = st_ff.level[0];
                end
                ADDR_LEVEL_TWO: begin
                    nxt_st.rdata = st_ff.level[1];
                end
                ADDR_LEVEL_THREE: begin
                    nxt_st.rdata = st_ff.level[2];
                end
                ADDR_LEVEL_FOUR: begin
                    nxt_st.rdata = st_ff.level[3];
                end
                ADDR_AUDIO_CTRL: begin
                    nxt_st.rdata = {st_ff.corner, st_ff.speed,
                        st_ff.gain_sel, st_ff.agc_en, st_ff.sync_en};
                end
                ADDR_THRESH: begin
                    nxt_st.rdata = {1'b0, st_ff.agc_code, st_ff.thresh};
                end
                ADDR_STATUS: begin
                    nxt_st.rdata = st_ff.audio_level;
                end
                default: begin
                    nxt_st.rdata = RST_RDATA;
                end
            endcase
        end

        // Magnitude of the filtered sample, clipped to 16 bits.
        mag_wide = hp_sample[16] ? 17'(-hp_sample) : 17'(hp_sample);
        mag = mag_wide[16] ? 16'hFFFF : mag_wide[15:0];
        peak_cand = st_ff.peak;
        if (hp_valid && (mag > st_ff.peak)) begin
            peak_cand = mag; // see (RL4)
        end

        // Slowly decaying envelope drives the automatic gain choice.
        env_decayed = st_ff.env - (st_ff.env >> ENV_DECAY_SHIFT);
        if (hp_valid) begin
            nxt_st.env = (mag > env_decayed) ? mag : env_decayed;
            nxt_st.agc_code = agc_pick(nxt_st.env); // see (RL14)
        end
        gain_code = st_ff.agc_en ? st_ff.agc_code : st_ff.gain_sel; // see (RL10)

        // Refresh timer; the fastest setting refreshes on every sample.
        rperiod = refresh_period(st_ff.speed);
        tick = 1'b0;
        if (st_ff.speed == 2'b00) begin
            tick = hp_valid; // see (RL12)
            nxt_st.rcnt = '0;
        end else if (count_up(st_ff.rcnt) >= rperiod) begin
            tick = 1'b1; // see (RL12)
            nxt_st.rcnt = '0;
        end else begin
            nxt_st.rcnt = count_up(st_ff.rcnt);
        end

        // A new peak window opens at every refresh tick.
        nxt_st.peak = peak_cand;
        if (tick) begin
            nxt_st.peak = '0;
            // The threshold meets the peak before gain, so it gates the
            // same noise whatever gain is chosen.
            if ((st_ff.thresh != 4'h0) &&
                (peak_cand < thr_limit(st_ff.thresh))) begin
                nxt_st.audio_level = 8'h00; // see (RL13) (RL17)
            end else begin
                nxt_st.audio_level = level_from_peak(peak_cand,
                    gain_code); // see (RL16)
            end
        end

        // Drive codes: an off sink draws nothing whatever its level.
        nxt_st.drv_on = st_ff.onoff; // see (RL1)
        for (int i = 0; i < 4; i++) begin
            nxt_st.drv_code[i] = gate_code(st_ff.onoff[i],
                st_ff.level[i]); // see (RL2) (RL3)
        end
        // Following replaces the written level of sink one, which stays
        // stored and readable and takes over again once following stops.
        if (st_ff.sync_en) begin
            nxt_st.drv_code[0] = gate_code(st_ff.onoff[0],
                st_ff.audio_level); // see (RL8) (RL9)
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff.onoff <= RST_ONOFF;
            st_ff.level <= {4{RST_LEVEL}};
            st_ff.sync_en <= RST_AUDIO_CTRL[AUD_SYNC_POS];
            st_ff.agc_en <= RST_AUDIO_CTRL[AUD_AGC_POS];
            st_ff.gain_sel <= RST_AUDIO_CTRL[AUD_GAIN_POS +: 3];
            st_ff.speed <= RST_AUDIO_CTRL[AUD_SPEED_POS +: 2];
            st_ff.corner <= RST_AUDIO_CTRL[AUD_CORNER_POS];
            st_ff.thresh <= RST_THRESH;
            st_ff.rdata <= RST_RDATA;
            st_ff.peak <= '0;
            st_ff.env <= '0;
            st_ff.agc_code <= '0;
            st_ff.audio_level <= '0;
            st_ff.rcnt <= '0;
            st_ff.drv_on <= '0;
            st_ff.drv_code <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // The sink DAC turns each code into code/255 of full-scale current.
    assign sink_out.on = st_ff.drv_on;
    assign sink_out.code = st_ff.drv_code; // see (RL3)
    assign reg_rdata = st_ff.rdata;

endmodule

`default_nettype wire

// >>> lsa_led_sink_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module lsa_led_sink_ctrl_props
    import lsa_pkg::*;
#(
    parameter int unsigned REFRESH_MID_CYCLES = 20,
    parameter int unsigned REFRESH_SLOW_CYCLES = 40,
    parameter int unsigned REFRESH_SLOWEST_CYCLES = 80
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port.
    input wire lsa_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Audio samples and sink drive.
    input wire lsa_audio_in_t audio_in,
    input wire lsa_sink_out_t sink_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Shadows of the on/off, level and audio control registers, updated on the same edge.
    logic [3:0] on_ff;
    logic [3:0][7:0] lvl_ff;
    logic [7:0] aud_ff;
    logic [3:0][7:0] drv_exp;
    logic [7:0] rd_exp;
    logic sync_on;
    logic spd_zero;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            on_ff <= 4'h0;
            lvl_ff <= '0;
            aud_ff <= 8'h00;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_ONOFF) begin
                on_ff <= reg_req.wdata[3:0];
            end
            if (reg_req.addr >= ADDR_LEVEL_ONE &&
                reg_req.addr <= ADDR_LEVEL_FOUR) begin
                lvl_ff[reg_req.addr[1:0] - 2'h1] <= reg_req.wdata;
            end
            if (reg_req.addr == ADDR_AUDIO_CTRL) begin
                aud_ff <= reg_req.wdata;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            drv_exp[i] = on_ff[i] ? lvl_ff[i] : 8'h00;
        end
        rd_exp = 8'h00;
        if (reg_req.addr == ADDR_ONOFF) begin
            rd_exp = {4'h0, on_ff};
        end
        if (reg_req.addr >= ADDR_LEVEL_ONE &&
            reg_req.addr <= ADDR_LEVEL_FOUR) begin
            rd_exp = lvl_ff[reg_req.addr[1:0] - 2'h1];
        end
        if (reg_req.addr == ADDR_AUDIO_CTRL) begin
            rd_exp = aud_ff;
        end
        sync_on = aud_ff[AUD_SYNC_POS];
        spd_zero = aud_ff[AUD_SPEED_POS +: 2] == 2'b00;
    end

    AST_ON_BITS: assert property (sink_out.on == $past(on_ff))
        else $error("sink on bits differ from the on/off register");
    AST_CODES_UPPER: assert property (
        sink_out.code[3:1] == $past(drv_exp[3:1]))
        else $error("sinks two to four drive the wrong code");
    AST_OFF_DARK: assert property (
        !sink_out.on[0] |-> sink_out.code[0] == 8'h00)
        else $error("sink one drives current while off");
    AST_MANUAL_ONE: assert property (
        !$past(sync_on) |-> sink_out.code[0] == $past(drv_exp[0]))
        else $error("sink one ignores its level with following off");
    // A change under following at the fastest rate needs a sample to cause it.
    AST_SYNC_HOLDS: assert property ($changed(sink_out.code[0]) &&
        $past(sync_on) && $past(sync_on, 2) && $past(on_ff[0]) &&
        $past(on_ff[0], 2) && $past(spd_zero) && $past(spd_zero, 2) |->
        $past(audio_in.valid, 2) || $past(audio_in.valid, 3) ||
        $past(audio_in.valid, 4))
        else $error("sink one moved without an audio sample");
    AST_READ_DATA: assert property (reg_req.rd &&
        (reg_req.addr <= ADDR_AUDIO_CTRL || reg_req.addr > ADDR_STATUS)
        |=> reg_rdata == $past(rd_exp))
        else $error("read data differs from the register");
    AST_READ_HOLD: assert property (
        !reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_RESET_QUIET: assert property (
        !$past(nrst) |-> sink_out == '0 && reg_rdata == 8'h00)
        else $error("outputs not quiet after reset");

    COV_ONOFF: cover property (reg_req.wr && reg_req.addr == ADDR_ONOFF);
    COV_AUDIO: cover property (sync_on && $changed(sink_out.code[0]));
    COV_READ: cover property (reg_req.rd ##1 reg_rdata != 8'h00);
endmodule

bind lsa_led_sink_ctrl lsa_led_sink_ctrl_props #(
    .REFRESH_MID_CYCLES(REFRESH_MID_CYCLES),
    .REFRESH_SLOW_CYCLES(REFRESH_SLOW_CYCLES),
    .REFRESH_SLOWEST_CYCLES(REFRESH_SLOWEST_CYCLES)
) u_props (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .audio_in(audio_in),
    .sink_out(sink_out)
);
`default_nettype wire

// >>> lsa_audio_src.sv
`timescale 1ns/1ps
`default_nettype none

// Stereo source behind the converter: a square tone on each channel and
// one sample every eight clocks.
module lsa_audio_src
    import lsa_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Swing of each channel around mid-scale.
    input wire logic [15:0] amp_a,
    input wire logic [15:0] amp_b,
    // Converter output.
    output var lsa_audio_in_t audio_in
);
    logic [6:0] cnt_ff;
    logic up;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 7'h00;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end

    always_comb begin
        up = cnt_ff[6];
        audio_in.valid = cnt_ff[2:0] == 3'h7;
        audio_in.a = up ? 16'h8000 + amp_a : 16'h8000 - amp_a;
        audio_in.b = up ? 16'h8000 + amp_b : 16'h8000 - amp_b;
        // Between strobes no sample is on the lines; a stale copy could
        // hide a design that samples at the wrong time.
        if (!audio_in.valid) begin
            audio_in.a = ~audio_in.a;
            audio_in.b = ~audio_in.b;
        end
    end
endmodule
`default_nettype wire

// >>> tb_led_sink_brightness_audio_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tb_led_sink_brightness_audio_sync
    import lsa_pkg::*;
;
    logic clk_sys;
    logic nrst;
    lsa_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    lsa_audio_in_t audio_in;
    lsa_sink_out_t sink_out;
    logic [15:0] amp_a;
    logic [15:0] amp_b;
    logic [7:0] got;
    logic [7:0] lv [4];
    logic [7:0] gl [8];
    int err_total;
    int num_checks;
    int cnt;

    lsa_led_sink_ctrl #(.REFRESH_MID_CYCLES(20), .REFRESH_SLOW_CYCLES(40),
        .REFRESH_SLOWEST_CYCLES(80)) DUT (.clk_sys(clk_sys), .nrst(nrst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .audio_in(audio_in),
        .sink_out(sink_out));
    lsa_audio_src u_src (.clk_sys(clk_sys), .nrst(nrst), .amp_a(amp_a),
        .amp_b(amp_b), .audio_in(audio_in));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_true(input string what, input logic cond);
        num_checks++;
        if (cond !== 1'b1) begin
            err_total++;
            $display("Error %s expected 1 seen %b", what, cond);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // The strobe is dropped an edge before the task returns, so calls may
    // follow each other without driving it twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= d;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_req.rd <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        idle(1);
        got = reg_rdata;
    endtask

    task automatic chk_codes(input logic [3:0] on);
        idle(1);
        for (int i = 0; i < 4; i++) begin
            chk("sink code", on[i] ? lv[i] : 8'h00, sink_out.code[i]);
        end
    endtask

    task automatic count_moves(input int n, output int moves);
        logic [7:0] prev;
        moves = 0;
        prev = sink_out.code[0];
        repeat (n) begin
            idle(1);
            if (sink_out.code[0] !== prev) moves++;
            prev = sink_out.code[0];
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        reg_req = '0;
        amp_a = 16'h0000;
        amp_b = 16'h0000;
        nrst = 1'b0;
        lv = '{8'hE0, 8'h01, 8'hFF, 8'h80};
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        // Offset 08 goes first and the status offsets straight after, before the first audio sample can
        // move them; offset 08 lies outside the map.
        for (int a = 8; a >= 0; a--) begin
            rd(8'(a));
            chk("reset value", 8'h00, got);
        end
        for (int i = 0; i < 4; i++) wr(ADDR_LEVEL_ONE + 8'(i), lv[i]);
        chk_codes(4'h0);
        wr(ADDR_ONOFF, 8'hFA);
        chk_codes(4'hA);
        wr(ADDR_ONOFF, 8'h0F);
        chk_codes(4'hF);
        rd(ADDR_ONOFF);
        chk("on/off readback", 8'h0F, got);
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_LEVEL_ONE + 8'(i));
            chk("level readback", lv[i], got);
        end
        wr(ADDR_LEVEL_ONE, 8'h00);
        wr(ADDR_AUDIO_CTRL, 8'h01);
        amp_a <= 16'h0030;
        amp_b <= 16'h0030;
        // Long settle so the start-up step has left the high-pass filter.
        idle(4500);
        for (int t = 0; t < 3; t++) begin
            wr(ADDR_THRESH, t == 2 ? 8'h0F : 8'(t));
            idle(200);
            got = sink_out.code[0];
            chk_true("threshold gate", (got != 8'h00) == (t < 2));
        end
        rd(ADDR_THRESH);
        chk("threshold readback", 8'h0F, got & 8'h0F);
        wr(ADDR_THRESH, 8'h00);
        amp_a <= 16'h7000;
        amp_b <= 16'h7000;
        wr(ADDR_AUDIO_CTRL, 8'h03);
        idle(300);
        got = sink_out.code[0];
        chk_true("auto level", got != 8'h00 && got != 8'hFF);
        rd(ADDR_THRESH);
        chk("auto gain code", 8'h70, got & 8'h70);
        for (int g = 0; g < 8; g++) begin
            wr(ADDR_AUDIO_CTRL, 8'(g * 4 + 1));
            idle(200);
            gl[g] = sink_out.code[0];
            chk_true("gain level", gl[g] != 8'h00);
            if (g > 0) chk_true("gain order", gl[g] <= gl[g - 1]);
        end
        chk_true("gain range", gl[7] > 8'h64 && gl[7] < 8'hBE);
        chk_true("gain span", gl[7] < gl[0]);
        wr(ADDR_ONOFF, 8'h0E);
        idle(1);
        chk("sink one off", 8'h00, sink_out.code[0]);
        wr(ADDR_ONOFF, 8'h0F);
        for (int c = 0; c < 2; c++) begin
            amp_a <= c ? 16'h0000 : 16'h7000;
            amp_b <= c ? 16'h7000 : 16'h0000;
            idle(200);
            got = sink_out.code[0];
            chk_true("one channel", got != 8'h00 && got < gl[7]);
        end
        amp_a <= 16'h7000;
        count_moves(400, cnt);
        chk_true("fast refresh", cnt > 6);
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_AUDIO_CTRL, 8'(s * 32 + 8'h1D));
            idle(100);
            count_moves(400, cnt);
            chk_true("slow refresh", cnt <= 400 / (20 << (s - 1)) + 1);
        end
        wr(ADDR_AUDIO_CTRL, 8'h9D);
        idle(200);
        chk_true("high corner", sink_out.code[0] != 8'h00);
        rd(ADDR_AUDIO_CTRL);
        chk("control readback", 8'h9D, got);
        wr(ADDR_LEVEL_ONE, 8'hFF);
        idle(1);
        chk_true("level unused", sink_out.code[0] != 8'hFF);
        wr(ADDR_AUDIO_CTRL, 8'h00);
        idle(1);
        chk("manual level", 8'hFF, sink_out.code[0]);
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        idle(1);
        chk("code after reset", 8'h00, sink_out.code[0]);
        complete_run();
    end
endmodule
`default_nettype wire
